// ---- cfpp_map.svh ----
`ifndef CFPP_MAP_SVH
`define CFPP_MAP_SVH
// ==========================================
// register word indices
`define CFPP_REG_CTRL 4'h0
`define CFPP_REG_AUX 4'h1
`define CFPP_REG_STAT 4'h2
// ==========================================
// flash_control_reg fields
`define CFPP_KEY_HI 7
`define CFPP_KEY_LO 4
`define CFPP_LSS_BIT 3
`define CFPP_SEL_HI_BIT 2
`define CFPP_SEL_LO_BIT 1
`define CFPP_BUSY_BIT 0
`define CFPP_CTRL_RESET 8'h00
// aux_control_reg fields
`define CFPP_EXT_RAM_SEL_BIT 1
`define CFPP_AUX_RESET 8'h00
// ==========================================
// launch keys and address map
`define CFPP_KEY_ARM 4'h5
`define CFPP_KEY_GO 4'hA
`define CFPP_USER_TOP 16'h7FFF
`define CFPP_EXTRA_ROW_BASE 16'hFF80
`define CFPP_SEC_ADDR 16'h0000
`define CFPP_PAGE_HI 14
`define CFPP_PAGE_LO 7
`define CFPP_PAGES 256
`define CFPP_PAGE_BYTES 128
`define CFPP_PROG_WAIT 64
`endif

// ---- cfpp_pkg.sv ----
`default_nettype none
package cfpp_pkg;
	// ==========================================
	// types
	typedef enum logic [1:0] {CFPP_EXEC_MAIN, CFPP_EXEC_BOOT, CFPP_EXEC_EXT} cfpp_exec_t;
	typedef enum logic [1:0] {CFPP_SEL_USER, CFPP_SEL_EXTRA_ROW, CFPP_SEL_SEC, CFPP_SEL_RSVD} cfpp_sel_t;
	typedef enum logic [1:0] {CFPP_IDLE, CFPP_COPY, CFPP_SETTLE} cfpp_state_t;
	typedef struct packed {
		logic wr;
		logic [15:0] addr;
		logic [7:0] data;
	} cfpp_xwr_t;
	typedef struct packed {
		logic req;
		logic [15:0] addr;
	} cfpp_crd_t;
endpackage : cfpp_pkg
`default_nettype wire

// ---- cfpp_flash_prog.sv ----
// Contract
// - user array is 32 KB in 256 pages of 128 bytes
// - separate 128-byte extra row kept beside the user array
// - security byte: upper nibble software-programmable, lower nibble only in parallel mode
// - 128-byte column latch page stages every programming operation
// - programming only launches while executing from boot flash
// - boot flash never written or latch-loaded by software
// - main code reads main; boot reads all; external with pin low gets nothing (code: main code reads every selected space, as boot does)
// - after reset user array is readable by code reads only
// - latch select routes data writes 0000h-7FFFh into column latches
// - address bits 6:0 pick byte, bits 14:7 record target page
// - latch select overrides external-RAM select for data writes
// - space select maps user, extra row, security byte; 11 reserved
// - launch only after key 5 then key A in consecutive control writes
// - destination taken from space select in the launching control write
// - control register shows programming busy
// - key 5 alone does nothing; key A programs selected space
//
// Local design decisions: the Avalon-MM slave port and the address map.
`include "cfpp_map.svh"
`default_nettype none
module cfpp_flash_prog #(
	parameter int PROG_WAIT = `CFPP_PROG_WAIT
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [3:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire cfpp_pkg::cfpp_exec_t exec_space,
	input wire logic external_access_pin,
	input wire logic par_prog_pin,
	input wire cfpp_pkg::cfpp_crd_t code_rd,
	output logic [7:0] code_rd_data,
	output logic code_rd_valid,
	output logic code_rd_denied,
	input wire cfpp_pkg::cfpp_xwr_t xdata_in,
	output cfpp_pkg::cfpp_xwr_t xram_out,
	output logic xram_ext,
	output logic prog_busy
);
	if (PROG_WAIT < 1 || PROG_WAIT > 65535) begin : g_bad_wait
		$error("PROG_WAIT out of range");
	end
	// ==========================================
	// storage
	logic [7:0] main_code_array [`CFPP_PAGES * `CFPP_PAGE_BYTES];
	logic [7:0] extra_row [`CFPP_PAGE_BYTES];
	logic [7:0] col_latch [`CFPP_PAGE_BYTES];
	logic [7:0] sec_byte;
	logic [7:0] ctrl;
	logic [7:0] aux_control_reg;
	logic key_armed;
	logic [7:0] prog_page;
	cfpp_pkg::cfpp_sel_t prog_sel;
	cfpp_pkg::cfpp_state_t state;
	logic [6:0] copy_idx;
	logic [15:0] wait_cnt;
	logic [2:0] ext_acc_sync;
	logic [2:0] par_sync;
	logic ext_acc_level;
	logic par_level;
	// ==========================================
	// pin inputs: three stages, change taken once stages two and three agree
	always_ff @(posedge mclk) begin
		if (rst) begin
			ext_acc_sync <= 3'h0;
			par_sync <= 3'h0;
			ext_acc_level <= 1'b0;
			par_level <= 1'b0;
		end else begin
			ext_acc_sync <= {ext_acc_sync[1:0], external_access_pin};
			par_sync <= {par_sync[1:0], par_prog_pin};
			if (ext_acc_sync[1] == ext_acc_sync[2]) ext_acc_level <= ext_acc_sync[2];
			if (par_sync[1] == par_sync[2]) par_level <= par_sync[2];
		end
	end
	// ==========================================
	// decode
	wire exec_boot = (exec_space == cfpp_pkg::CFPP_EXEC_BOOT);
	wire exec_blocked = (exec_space == cfpp_pkg::CFPP_EXEC_EXT) && !ext_acc_level;
	wire busy = (state != cfpp_pkg::CFPP_IDLE);
	wire latch_space_select = ctrl[`CFPP_LSS_BIT];
	wire [1:0] cur_sel = {ctrl[`CFPP_SEL_HI_BIT], ctrl[`CFPP_SEL_LO_BIT]};
	wire bus_req = (read || write) && waitrequest;
	wire [3:0] key_in = writedata[`CFPP_KEY_HI:`CFPP_KEY_LO];
	wire [1:0] sel_in = {writedata[`CFPP_SEL_HI_BIT], writedata[`CFPP_SEL_LO_BIT]};
	// the boot array has no data-space path at all, so it cannot be loaded or written
	wire latch_load = xdata_in.wr && latch_space_select && (xdata_in.addr <= `CFPP_USER_TOP)
		&& !exec_blocked && !busy;
	wire [7:0] stat_word = {4'h0, par_level, ext_acc_level, exec_space};
	wire [7:0] ctrl_word = {ctrl[7:1], busy};
	wire [7:0] rd_mux = (address == `CFPP_REG_CTRL) ? ctrl_word :
		(address == `CFPP_REG_AUX) ? aux_control_reg :
		(address == `CFPP_REG_STAT) ? stat_word : 8'h00;
	// ==========================================
	// avalon slave: one wait cycle, then answer
	always_ff @(posedge mclk) begin
		if (rst) begin
			waitrequest <= 1'b1;
			readdata <= 32'h0;
		end else begin
			waitrequest <= !bus_req;
			if (read && waitrequest) readdata <= {24'h0, rd_mux};
		end
	end
	// writes act on the edge where waitrequest is already low
	wire wr_go = write && !waitrequest && byteenable[0];
	wire ctrl_wr_go = wr_go && (address == `CFPP_REG_CTRL);
	wire aux_wr_go = wr_go && (address == `CFPP_REG_AUX);
	// key A only counts straight after key 5, from boot code, when idle and selectable
	wire launch_go = ctrl_wr_go && key_armed && (key_in == `CFPP_KEY_GO) && exec_boot && !busy
		&& (sel_in != 2'h3);
	// ==========================================
	// control registers and key sequencer
	always_ff @(posedge mclk) begin
		if (rst) begin
			ctrl <= `CFPP_CTRL_RESET;
			aux_control_reg <= `CFPP_AUX_RESET;
			key_armed <= 1'b0;
			prog_sel <= cfpp_pkg::CFPP_SEL_USER;
		end else begin
			if (ctrl_wr_go) begin
				ctrl <= {writedata[7:1], 1'b0};
				key_armed <= (key_in == `CFPP_KEY_ARM);
			end
			if (aux_wr_go) aux_control_reg <= writedata[7:0];
			if (launch_go) prog_sel <= cfpp_pkg::cfpp_sel_t'(sel_in);
		end
	end
	dest_pick_a: assert property (@(posedge mclk) disable iff (rst)
		launch_go |=> prog_sel == cfpp_pkg::cfpp_sel_t'($past(sel_in)))
		else $error("destination not taken from launch write");
	relaunch_ignore_a: assert property (@(posedge mclk) disable iff (rst)
		busy && ctrl_wr_go |=> prog_sel == $past(prog_sel))
		else $error("launch accepted while busy");
	main_nolaunch_a: assert property (@(posedge mclk) disable iff (rst)
		ctrl_wr_go && !exec_boot && !busy |=> !prog_busy)
		else $error("launch from non-boot code");
	reset_state_a: assert property (@(posedge mclk)
		rst |=> ctrl == `CFPP_CTRL_RESET && !prog_busy && waitrequest)
		else $error("reset state wrong");
	// ==========================================
	// programming sequencer
	always_ff @(posedge mclk) begin
		if (rst) begin
			state <= cfpp_pkg::CFPP_IDLE;
			copy_idx <= 7'h0;
			wait_cnt <= 16'h0;
			prog_busy <= 1'b0;
		end else begin
			case (state)
				cfpp_pkg::CFPP_IDLE: begin
					copy_idx <= 7'h0;
					if (launch_go) state <= cfpp_pkg::CFPP_COPY;
				end
				cfpp_pkg::CFPP_COPY: begin
					copy_idx <= copy_idx + 7'h1;
					wait_cnt <= 16'(PROG_WAIT);
					if (copy_idx == 7'h7F) state <= cfpp_pkg::CFPP_SETTLE;
				end
				default: begin
					wait_cnt <= wait_cnt - 16'h1;
					if (wait_cnt == 16'h1) state <= cfpp_pkg::CFPP_IDLE;
				end
			endcase
			prog_busy <= (state == cfpp_pkg::CFPP_IDLE) ? launch_go
				: !(state == cfpp_pkg::CFPP_SETTLE && wait_cnt == 16'h1);
		end
	end
	busy_span_a: assert property (@(posedge mclk) disable iff (rst)
		$rose(prog_busy) |-> ##128 prog_busy)
		else $error("busy dropped before page copied");
	busy_clear_a: assert property (@(posedge mclk) disable iff (rst)
		state == cfpp_pkg::CFPP_SETTLE && wait_cnt == 16'h1 |=> !prog_busy)
		else $error("busy not cleared at end");
	busy_read_a: assert property (@(posedge mclk) disable iff (rst)
		read && waitrequest && address == `CFPP_REG_CTRL |=> readdata[0] == $past(prog_busy))
		else $error("control busy bit wrong");
	// ==========================================
	// array and latch updates; the array is not reset, as flash keeps its content
	always_ff @(posedge mclk) begin
		if (latch_load) begin
			col_latch[xdata_in.addr[6:0]] <= xdata_in.data;
		end
		if (state == cfpp_pkg::CFPP_COPY) begin
			case (prog_sel)
				cfpp_pkg::CFPP_SEL_USER: main_code_array[{prog_page, copy_idx}] <= col_latch[copy_idx];
				cfpp_pkg::CFPP_SEL_EXTRA_ROW: extra_row[copy_idx] <= col_latch[copy_idx];
				default: ;
			endcase
		end
	end
	always_ff @(posedge mclk) begin
		if (rst) begin
			prog_page <= 8'h00;
			sec_byte <= 8'hFF;
		end else begin
			if (latch_load) prog_page <= xdata_in.addr[`CFPP_PAGE_HI:`CFPP_PAGE_LO];
			if (state == cfpp_pkg::CFPP_COPY && copy_idx == 7'h0 && prog_sel == cfpp_pkg::CFPP_SEL_SEC) begin
				sec_byte[7:4] <= col_latch[0][7:4];
				if (par_level) sec_byte[3:0] <= col_latch[0][3:0];
			end
		end
	end
	latch_store_a: assert property (@(posedge mclk) disable iff (rst)
		latch_load |=> col_latch[$past(xdata_in.addr[6:0])] == $past(xdata_in.data))
		else $error("latch byte not stored");
	user_copy_a: assert property (@(posedge mclk) disable iff (rst)
		state == cfpp_pkg::CFPP_COPY && prog_sel == cfpp_pkg::CFPP_SEL_USER |=>
		main_code_array[$past({prog_page, copy_idx})] == $past(col_latch[copy_idx]))
		else $error("user page byte not copied");
	row_copy_a: assert property (@(posedge mclk) disable iff (rst)
		state == cfpp_pkg::CFPP_COPY && prog_sel == cfpp_pkg::CFPP_SEL_EXTRA_ROW |=>
		extra_row[$past(copy_idx)] == $past(col_latch[copy_idx]))
		else $error("extra row byte not copied");
	sec_high_a: assert property (@(posedge mclk) disable iff (rst)
		state == cfpp_pkg::CFPP_COPY && copy_idx == 7'h0 && prog_sel == cfpp_pkg::CFPP_SEL_SEC |=>
		sec_byte[7:4] == $past(col_latch[0][7:4]))
		else $error("security upper nibble not programmed");
	sec_low_a: assert property (@(posedge mclk) disable iff (rst)
		state == cfpp_pkg::CFPP_COPY && copy_idx == 7'h0 && prog_sel == cfpp_pkg::CFPP_SEL_SEC && !par_level |=>
		sec_byte[3:0] == $past(sec_byte[3:0]))
		else $error("security lower nibble changed");
	// ==========================================
	// data-space write routing
	always_ff @(posedge mclk) begin
		if (rst) begin
			xram_out <= '0;
			xram_ext <= 1'b0;
		end else begin
			// latch space wins over external RAM select for 0000h-7FFFh
			xram_out.wr <= xdata_in.wr && !(latch_space_select && (xdata_in.addr <= `CFPP_USER_TOP));
			xram_out.addr <= xdata_in.addr;
			xram_out.data <= xdata_in.data;
			xram_ext <= aux_control_reg[`CFPP_EXT_RAM_SEL_BIT];
		end
	end
	ram_pass_a: assert property (@(posedge mclk) disable iff (rst)
		xdata_in.wr && !latch_space_select |=> xram_out.wr && xram_out.addr == $past(xdata_in.addr))
		else $error("data write not passed to ram");
	high_addr_a: assert property (@(posedge mclk) disable iff (rst)
		xdata_in.wr && xdata_in.addr > `CFPP_USER_TOP |=> xram_out.wr)
		else $error("write above latch range not passed");
	// ==========================================
	// code-space reads
	wire rd_user = (cur_sel == 2'h0) && (code_rd.addr <= `CFPP_USER_TOP);
	wire rd_extra_row = (cur_sel == 2'h1) && (code_rd.addr >= `CFPP_EXTRA_ROW_BASE);
	wire rd_sec = (cur_sel == 2'h2) && (code_rd.addr == `CFPP_SEC_ADDR);
	wire rd_ok = code_rd.req && !exec_blocked && (rd_user || rd_extra_row || rd_sec);
	always_ff @(posedge mclk) begin
		if (rst) begin
			code_rd_data <= 8'h00;
			code_rd_valid <= 1'b0;
			code_rd_denied <= 1'b0;
		end else begin
			code_rd_valid <= rd_ok;
			code_rd_denied <= code_rd.req && !rd_ok;
			if (!rd_ok) code_rd_data <= 8'h00;
			else if (rd_user) code_rd_data <= main_code_array[code_rd.addr[14:0]];
			else if (rd_extra_row) code_rd_data <= extra_row[code_rd.addr[6:0]];
			else code_rd_data <= sec_byte;
		end
	end
	user_read_a: assert property (@(posedge mclk) disable iff (rst)
		code_rd.req && rd_user && !exec_blocked |=> code_rd_valid && !code_rd_denied)
		else $error("user array read refused");
	row_read_a: assert property (@(posedge mclk) disable iff (rst)
		code_rd.req && rd_extra_row && !exec_blocked |=> code_rd_data == $past(extra_row[code_rd.addr[6:0]]))
		else $error("extra row read wrong");
	// ==========================================
	// checks
	wire unused_ok = &{1'b0, writedata[31:8], byteenable[3:1]};
	busy_start_a: assert property (@(posedge mclk) disable iff (rst) launch_go |=> prog_busy)
		else $error("busy not raised after launch");
	key_order_a: assert property (@(posedge mclk) disable iff (rst)
		$rose(prog_busy) |-> $past(key_armed) && $past(writedata[7:4]) == 4'hA)
		else $error("launch without ordered keys");
	boot_only_a: assert property (@(posedge mclk) disable iff (rst)
		$rose(prog_busy) |-> $past(exec_space) == cfpp_pkg::CFPP_EXEC_BOOT)
		else $error("launch outside boot code");
	busy_hold_a: assert property (@(posedge mclk) disable iff (rst)
		$rose(prog_busy) |=> prog_busy [*8])
		else $error("busy dropped early");
	latch_route_a: assert property (@(posedge mclk) disable iff (rst)
		xdata_in.wr && latch_space_select && xdata_in.addr < 16'h8000 |=> !xram_out.wr)
		else $error("latch write leaked to ram");
	page_rec_a: assert property (@(posedge mclk) disable iff (rst)
		latch_load |=> prog_page == $past(xdata_in.addr[14:7]))
		else $error("page address not recorded");
	ext_deny_a: assert property (@(posedge mclk) disable iff (rst)
		code_rd.req && exec_space == cfpp_pkg::CFPP_EXEC_EXT && !ext_acc_level |=> code_rd_denied)
		else $error("external read not denied");
	rsvd_deny_a: assert property (@(posedge mclk) disable iff (rst)
		code_rd.req && cur_sel == 2'h3 |=> code_rd_denied && !code_rd_valid)
		else $error("reserved space readable");
	arm_only_a: assert property (@(posedge mclk) disable iff (rst)
		ctrl_wr_go && writedata[7:4] == 4'h5 && !busy |=> !prog_busy)
		else $error("key 5 started programming");
	bus_wait_a: assert property (@(posedge mclk) disable iff (rst)
		(read || write) && waitrequest |=> !waitrequest)
		else $error("bus answer late");
endmodule : cfpp_flash_prog
`default_nettype wire

// ---- cfpp_cpu_model.sv ----
`default_nettype none
module cfpp_cpu_model (
	input wire logic mclk,
	output cfpp_pkg::cfpp_exec_t exec_space,
	output cfpp_pkg::cfpp_crd_t code_rd,
	output cfpp_pkg::cfpp_xwr_t xdata_in,
	input wire logic [7:0] code_rd_data,
	input wire logic code_rd_valid,
	input wire logic code_rd_denied,
	input wire cfpp_pkg::cfpp_xwr_t xram_out
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		exec_space = cfpp_pkg::CFPP_EXEC_BOOT;
		code_rd = '0;
		xdata_in = '0;
	end
	// ==========================================
	// cpu side tasks
	task automatic run_from(input cfpp_pkg::cfpp_exec_t e);
		exec_space <= e;
		@(posedge mclk);
	endtask : run_from
	// released fields are inverted so nothing relies on stale values
	task automatic rd(input logic [15:0] a, output logic ok, output logic [7:0] d);
		code_rd <= '{1'b1, a};
		@(posedge mclk);
		code_rd <= '{1'b0, ~a};
		@(posedge mclk);
		ok = code_rd_valid & ~code_rd_denied;
		d = code_rd_data;
	endtask : rd
	task automatic wr(input logic [15:0] a, input logic [7:0] d, output cfpp_pkg::cfpp_xwr_t o);
		xdata_in <= '{1'b1, a, d};
		@(posedge mclk);
		xdata_in <= '{1'b0, ~a, ~d};
		@(posedge mclk);
		o = xram_out;
	endtask : wr
endmodule : cfpp_cpu_model
`default_nettype wire

// ---- test_code_flash_page_programmer.sv ----
`default_nettype none
module test_code_flash_page_programmer;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int WAIT_CYC = 4;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] address = 4'h0;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [31:0] readdata;
	logic waitrequest;
	logic ext_acc_pin = 1'b1;
	logic par_pin = 1'b0;
	cfpp_pkg::cfpp_exec_t exec_space;
	cfpp_pkg::cfpp_crd_t code_rd;
	cfpp_pkg::cfpp_xwr_t xdata_in, xram_out, xo;
	logic [7:0] code_rd_data, q, d;
	logic code_rd_valid, code_rd_denied, xram_ext, prog_busy, ok;
	int n_fail = 0;
	int n_checks = 0;
	int cyc = 0;
	int t0;
	always #20 mclk = ~mclk;
	cfpp_flash_prog #(.PROG_WAIT(WAIT_CYC)) cfpp_flash_prog_i (.mclk(mclk), .rst(rst), .address(address),
		.read(read), .write(write), .writedata(writedata), .byteenable(4'hF), .readdata(readdata),
		.waitrequest(waitrequest), .exec_space(exec_space), .external_access_pin(ext_acc_pin),
		.par_prog_pin(par_pin), .code_rd(code_rd), .code_rd_data(code_rd_data), .code_rd_valid(code_rd_valid),
		.code_rd_denied(code_rd_denied), .xdata_in(xdata_in), .xram_out(xram_out), .xram_ext(xram_ext),
		.prog_busy(prog_busy));
	cfpp_cpu_model cfpp_cpu_model_i (.mclk(mclk), .exec_space(exec_space), .code_rd(code_rd),
		.xdata_in(xdata_in), .code_rd_data(code_rd_data), .code_rd_valid(code_rd_valid),
		.code_rd_denied(code_rd_denied), .xram_out(xram_out));
	// ==========================================
	// helpers
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			n_fail++;
		end
	endtask : chk
	task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] dt);
		write <= wr;
		read <= ~wr;
		address <= a;
		writedata <= {24'h000000, dt};
		do @(posedge mclk); while (waitrequest !== 1'b0);
		q = readdata[7:0];
		write <= 1'b0;
		read <= 1'b0;
		@(posedge mclk);
	endtask : bus
	// bounded so a stuck busy flag ends as a mismatch, not a hang
	task automatic wait_idle();
		for (int i = 0; i < 400 && prog_busy !== 1'b0; i++) @(posedge mclk);
		chk({7'h00, prog_busy}, 8'h00);
	endtask : wait_idle
	task automatic test_done();
		$display("checks %0d failures %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : test_done
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			n_fail++;
			test_done();
		end
	end
	// ==========================================
	// sequence
	initial begin
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		repeat (8) @(posedge mclk);
		bus(1'b0, 4'h0, 8'h00);
		chk(q, 8'h00);
		bus(1'b0, 4'hF, 8'h00);
		chk(q, 8'h00);
		bus(1'b0, 4'h2, 8'h00);
		chk(q, 8'h05);
		cfpp_cpu_model_i.rd(16'h0105, ok, d);
		chk({7'h00, ok}, 8'h01);
		bus(1'b1, 4'h1, 8'h02);
		cfpp_cpu_model_i.wr(16'h1234, 8'hC3, xo);
		chk({xo.wr, xo.data[6:0]}, 8'hC3);
		chk({7'h00, xram_ext}, 8'h01);
		bus(1'b1, 4'h0, 8'h08);
		cfpp_cpu_model_i.wr(16'h0105, 8'h3C, xo);
		chk({7'h00, xo.wr}, 8'h00);
		cfpp_cpu_model_i.wr(16'h017F, 8'h96, xo);
		cfpp_cpu_model_i.wr(16'h8000, 8'h11, xo);
		chk({7'h00, xo.wr}, 8'h01);
		t0 = cyc;
		bus(1'b1, 4'h0, 8'h58);
		bus(1'b1, 4'h0, 8'hA8);
		bus(1'b0, 4'h0, 8'h00);
		chk(q & 8'h01, 8'h01);
		bus(1'b1, 4'h0, 8'h5A);
		bus(1'b1, 4'h0, 8'hAA);
		chk({7'h00, prog_busy}, 8'h01);
		wait_idle();
		chk(8'((cyc - t0) < 128 + WAIT_CYC + 24), 8'h01);
		bus(1'b1, 4'h0, 8'h00);
		cfpp_cpu_model_i.rd(16'h0105, ok, d);
		chk(d, 8'h3C);
		cfpp_cpu_model_i.rd(16'h017F, ok, d);
		chk(d, 8'h96);
		bus(1'b1, 4'h0, 8'h50);
		bus(1'b1, 4'h0, 8'h00);
		bus(1'b1, 4'h0, 8'hA0);
		chk({7'h00, prog_busy}, 8'h00);
		cfpp_cpu_model_i.run_from(cfpp_pkg::CFPP_EXEC_MAIN);
		bus(1'b1, 4'h0, 8'h50);
		bus(1'b1, 4'h0, 8'hA0);
		chk({7'h00, prog_busy}, 8'h00);
		cfpp_cpu_model_i.rd(16'h0105, ok, d);
		chk(d, 8'h3C);
		ext_acc_pin <= 1'b0;
		repeat (8) @(posedge mclk);
		cfpp_cpu_model_i.run_from(cfpp_pkg::CFPP_EXEC_EXT);
		cfpp_cpu_model_i.rd(16'h0105, ok, d);
		chk({ok, d[6:0]}, 8'h00);
		ext_acc_pin <= 1'b1;
		repeat (8) @(posedge mclk);
		cfpp_cpu_model_i.run_from(cfpp_pkg::CFPP_EXEC_BOOT);
		bus(1'b1, 4'h0, 8'h0A);
		cfpp_cpu_model_i.wr(16'h0003, 8'h77, xo);
		bus(1'b1, 4'h0, 8'h5A);
		bus(1'b1, 4'h0, 8'hAA);
		wait_idle();
		bus(1'b1, 4'h0, 8'h02);
		cfpp_cpu_model_i.rd(16'hFF83, ok, d);
		chk(d, 8'h77);
		bus(1'b1, 4'h0, 8'h0C);
		cfpp_cpu_model_i.wr(16'h0000, 8'h50, xo);
		bus(1'b1, 4'h0, 8'h5C);
		bus(1'b1, 4'h0, 8'hAC);
		wait_idle();
		bus(1'b1, 4'h0, 8'h04);
		cfpp_cpu_model_i.rd(16'h0000, ok, d);
		chk(d, 8'h5F);
		par_pin <= 1'b1;
		repeat (8) @(posedge mclk);
		bus(1'b1, 4'h0, 8'h0C);
		cfpp_cpu_model_i.wr(16'h0000, 8'hA3, xo);
		bus(1'b1, 4'h0, 8'h5C);
		bus(1'b1, 4'h0, 8'hAC);
		wait_idle();
		bus(1'b1, 4'h0, 8'h04);
		cfpp_cpu_model_i.rd(16'h0000, ok, d);
		chk(d, 8'hA3);
		bus(1'b1, 4'h0, 8'h06);
		cfpp_cpu_model_i.rd(16'h0000, ok, d);
		chk({7'h00, ok}, 8'h00);
		test_done();
	end
endmodule : test_code_flash_page_programmer
`default_nettype wire
